// ==== design/frtc_timer.sv ====
// free running 16-bit timer counter with overflow flag and coherent byte reads
// assumes synchronous inputs on I_CORE_CLK and a register master that never waits
`timescale 1ns/10ps

// Notes on behaviour
// - sixteen-bit up counter advances each timer tick
// - internal tick is core clock over 2/4/8
// - full period is 65536 ticks of prescaler
// - any low byte write loads FFFC
// - alternate pair same, never clears overflow
// - high byte read buffers the low byte
// - buffer frozen until low byte read
// - lone low read returns live count
// - wrap from FFFF to 0000 sets overflow
// - interrupt needs enable and clear global mask
// - clear: status read, then main low access
// - counting continues in wait mode
// - halt freezes count; reset restarts it
// - both clock select bits pick external pin
// - edge select picks rising or falling edge
// - counter updates only on core clock edge
// - unbonded timer input reads as one
module frtc_timer #(
  parameter bit EXT_CLOCK_PIN_BONDED = 1'b1
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_EXT_CLOCK_PIN,
  input wire logic I_CPU_IMASK,
  input wire logic I_HALT,
  output logic O_IRQ
);

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_clr;
  logic wr_low_main;
  logic wr_low_alt;
  logic rd_status;
  logic rd_high;
  logic rd_low_main;
  logic rd_low_alt;
  logic cnt_load;

  assign wr_ctrl1 = I_WR && (I_ADDR == frtc_pkg::OFS_CTRL1);
  assign wr_ctrl2 = I_WR && (I_ADDR == frtc_pkg::OFS_CTRL2);
  assign wr_clr = I_WR && (I_ADDR == frtc_pkg::OFS_STATUS_CLR);
  assign wr_low_main = I_WR && (I_ADDR == frtc_pkg::OFS_CNT_LOW);
  assign wr_low_alt = I_WR && (I_ADDR == frtc_pkg::OFS_ALT_LOW);
  assign rd_status = I_RD && (I_ADDR == frtc_pkg::OFS_STATUS);
  assign rd_high = I_RD && ((I_ADDR == frtc_pkg::OFS_CNT_HIGH) || (I_ADDR == frtc_pkg::OFS_ALT_HIGH));
  assign rd_low_main = I_RD && (I_ADDR == frtc_pkg::OFS_CNT_LOW);
  assign rd_low_alt = I_RD && (I_ADDR == frtc_pkg::OFS_ALT_LOW);
  assign cnt_load = wr_low_main || wr_low_alt;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  frtc_pkg::frtc_clk_sel_t clk_sel;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl1 <= frtc_pkg::CTRL1_RESET;
    end else if (wr_ctrl1) begin
      ctrl1 <= I_WDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl2 <= frtc_pkg::CTRL2_RESET;
    end else if (wr_ctrl2) begin
      ctrl2 <= I_WDATA;
    end
  end

  assign clk_sel = frtc_pkg::frtc_clk_sel_t'({ctrl2[frtc_pkg::BIT_CLK_SEL_HIGH], ctrl2[frtc_pkg::BIT_CLK_SEL_LOW]});

  // ----------------------------------------
  // tick generation
  // ----------------------------------------
  // the prescaler runs free, so a new division takes effect at the next
  // aligned boundary; the external edge is found against the previous sample,
  // which relies on the source keeping edges at least one core clock apart
  logic [2:0] pre;
  logic ext_level;
  logic ext_prev;
  logic ext_edge;
  logic tick;

  assign ext_level = EXT_CLOCK_PIN_BONDED ? I_EXT_CLOCK_PIN : 1'b1;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre <= 3'h0;
    end else begin
      pre <= pre + 3'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ext_prev <= 1'b1;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // rising edge when edge select is one, falling edge otherwise
  assign ext_edge = ctrl2[frtc_pkg::BIT_EXT_EDGE_SEL] ? (ext_level && !ext_prev) : (!ext_level && ext_prev);

  always_comb begin
    case (clk_sel)
      frtc_pkg::FRTC_DIV2: tick = ((pre & frtc_pkg::PRE_MASK_DIV2) == frtc_pkg::PRE_MASK_DIV2);
      frtc_pkg::FRTC_DIV4: tick = ((pre & frtc_pkg::PRE_MASK_DIV4) == frtc_pkg::PRE_MASK_DIV4);
      frtc_pkg::FRTC_DIV8: tick = ((pre & frtc_pkg::PRE_MASK_DIV8) == frtc_pkg::PRE_MASK_DIV8);
      frtc_pkg::FRTC_EXT: tick = ext_edge;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // halt only gates the tick; wait mode has no input here so counting goes on
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic wrap;

  assign wrap = tick && !I_HALT && !cnt_load && (cnt == frtc_pkg::CNT_MAX);

  always_comb begin
    next_cnt = cnt;
    if (cnt_load) begin
      next_cnt = frtc_pkg::CNT_RESET;
    end else if (tick && !I_HALT) begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // every update lands on one core clock edge, so external events are aligned too
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt <= frtc_pkg::CNT_RESET;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // coherent 16-bit read
  // ----------------------------------------
  logic seq;
  logic [7:0] low_buf;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      seq <= 1'b0;
      low_buf <= 8'h00;
    end else if (rd_high && !seq) begin
      seq <= 1'b1;
      low_buf <= cnt[7:0];
    end else if (rd_low_main || rd_low_alt) begin
      seq <= 1'b0;
    end
  end

  // ----------------------------------------
  // overflow flag and its two step clear
  // ----------------------------------------
  logic ovf;
  logic armed;
  logic ovf_clear;

  assign ovf_clear = (armed && (rd_low_main || wr_low_main)) || (wr_clr && I_WDATA[frtc_pkg::BIT_OVF]);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ovf <= 1'b0;
    end else if (wrap) begin
      ovf <= 1'b1;
    end else if (ovf_clear) begin
      ovf <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      armed <= 1'b0;
    end else if (rd_status && ovf) begin
      armed <= 1'b1;
    end else if (ovf_clear || !ovf) begin
      armed <= 1'b0;
    end
  end

  // pending request waits for both enable and a clear global mask
  assign O_IRQ = ovf && ctrl1[frtc_pkg::BIT_OVF_IRQ_EN] && !I_CPU_IMASK;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[frtc_pkg::BIT_OVF] = ovf;
    status[frtc_pkg::BIT_EXT_LEVEL] = ext_level;
  end

  always_comb begin
    case (I_ADDR)
      frtc_pkg::OFS_CTRL1: next_rdata = ctrl1;
      frtc_pkg::OFS_CTRL2: next_rdata = ctrl2;
      frtc_pkg::OFS_STATUS: next_rdata = status;
      frtc_pkg::OFS_CNT_HIGH: next_rdata = cnt[15:8];
      frtc_pkg::OFS_ALT_HIGH: next_rdata = cnt[15:8];
      frtc_pkg::OFS_CNT_LOW: next_rdata = seq ? low_buf : cnt[7:0];
      frtc_pkg::OFS_ALT_LOW: next_rdata = seq ? low_buf : cnt[7:0];
      default: next_rdata = frtc_pkg::RDATA_UNMAPPED;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  // a control write lands one cycle later, so the tick cycle itself must be free of it
  sequence s_div2_tick;
    tick && !I_HALT && !cnt_load && !wr_ctrl2 && (clk_sel == frtc_pkg::FRTC_DIV2);
  endsequence

  sequence s_div2_gap;
    !tick ##1 tick;
  endsequence

  sequence s_div4_tick;
    tick && !wr_ctrl2 && (clk_sel == frtc_pkg::FRTC_DIV4);
  endsequence

  sequence s_div4_gap;
    !tick [*3] ##1 tick;
  endsequence

  sequence s_div8_tick;
    tick && !wr_ctrl2 && (clk_sel == frtc_pkg::FRTC_DIV8);
  endsequence

  sequence s_div8_gap;
    !tick [*7] ##1 tick;
  endsequence

  sequence s_armed_clear;
    rd_status && ovf && !wrap ##1 (rd_low_main || wr_low_main) && !wrap;
  endsequence

  AST_LOAD_ON_LOW_WRITE: assert property (cnt_load |=> cnt == frtc_pkg::CNT_RESET)
    else $error("low byte write did not load FFFC");

  AST_COUNT_STEP: assert property (tick && !I_HALT && !cnt_load |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not advance by one on a tick");

  AST_HALT_HOLDS: assert property (I_HALT && !cnt_load |=> $stable(cnt))
    else $error("counter moved during halt");

  AST_DIV2_PERIOD: assert property (s_div2_tick |=> s_div2_gap or wr_ctrl2)
    else $error("divide by two tick spacing wrong");

  AST_WRAP_SETS_FLAG: assert property (wrap |=> ovf && (cnt == 16'h0000))
    else $error("wrap did not set overflow flag");

  AST_IRQ_GATED: assert property (ovf && ctrl1[frtc_pkg::BIT_OVF_IRQ_EN] && !I_CPU_IMASK |-> O_IRQ)
    else $error("enabled overflow did not raise interrupt");

  AST_IRQ_MASKED: assert property (I_CPU_IMASK |-> !O_IRQ)
    else $error("interrupt raised while globally masked");

  AST_TWO_STEP_CLEAR: assert property (s_armed_clear |=> !ovf)
    else $error("two step access did not clear flag");

  AST_NO_CLEAR_UNARMED: assert property (ovf && !armed && !wr_clr |=> ovf)
    else $error("overflow flag cleared without status read first");

  AST_BUF_FROZEN: assert property (seq && !rd_low_main && !rd_low_alt |=> $stable(low_buf) && seq)
    else $error("buffered low byte changed mid sequence");

  AST_BUF_RETURN: assert property (rd_high && !seq ##1 (rd_low_main || rd_low_alt) |=> O_RDATA == $past(cnt[7:0], 2))
    else $error("low byte not coherent with high byte read");

  AST_LIVE_LOW: assert property ((rd_low_main || rd_low_alt) && !seq |=> O_RDATA == $past(cnt[7:0]))
    else $error("lone low read did not return live count");

  AST_EXT_TICK: assert property ((clk_sel == frtc_pkg::FRTC_EXT) && ext_edge && !I_HALT && !cnt_load |=> cnt == $past(cnt) + 16'h0001)
    else $error("external edge did not advance counter");

  AST_DIV4_PERIOD: assert property (s_div4_tick |=> s_div4_gap or (##[0:2] wr_ctrl2))
    else $error("divide by four tick spacing wrong");

  AST_DIV8_PERIOD: assert property (s_div8_tick |=> s_div8_gap or (##[0:6] wr_ctrl2))
    else $error("divide by eight tick spacing wrong");

  AST_HIGH_LIVE: assert property (rd_high |=> O_RDATA == $past(cnt[15:8]))
    else $error("high byte read did not return live count");

  AST_BUF_CAPTURE: assert property (rd_high && !seq |=> seq && (low_buf == $past(cnt[7:0])))
    else $error("high byte read did not buffer the low byte");

  AST_LOW_ENDS_SEQ: assert property (rd_low_main || rd_low_alt |=> !seq)
    else $error("low byte read did not end the read sequence");

  AST_ALT_NO_CLEAR: assert property (ovf && rd_low_alt |=> ovf)
    else $error("alternate low read cleared overflow flag");

  AST_EXT_WRONG_EDGE: assert property ((clk_sel == frtc_pkg::FRTC_EXT) && !ext_edge && !cnt_load |=> $stable(cnt))
    else $error("counter moved without an active external edge");

  AST_IRQ_NEEDS_ENABLE: assert property (!ctrl1[frtc_pkg::BIT_OVF_IRQ_EN] |-> !O_IRQ)
    else $error("interrupt raised while overflow interrupt disabled");

endmodule // frtc_timer

// ==== design/frtc_pkg.sv ====
// package of the free running timer counter: register map, fields, reset values
// assumes a byte wide register port and a single core clock
package frtc_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_STATUS_CLR = 8'h03;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_CNT_LOW = 8'h09;
  localparam logic [7:0] OFS_ALT_HIGH = 8'h0A;
  localparam logic [7:0] OFS_ALT_LOW = 8'h0B;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_OVF = 5;
  localparam int BIT_OVF_IRQ_EN = 5;
  localparam int BIT_CLK_SEL_HIGH = 3;
  localparam int BIT_CLK_SEL_LOW = 2;
  localparam int BIT_EXT_EDGE_SEL = 0;
  localparam int BIT_EXT_LEVEL = 0;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    FRTC_DIV4 = 2'b00,
    FRTC_DIV2 = 2'b01,
    FRTC_DIV8 = 2'b10,
    FRTC_EXT = 2'b11
  } frtc_clk_sel_t;

  localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
  localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
  localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

endpackage

// ==== test/frtc_testbench.sv ====
// directed testbench for the free running timer counter, driven over its register port
// assumes frtc_pkg and frtc_timer are compiled first; one 50 MHz core clock
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] A_C1 = frtc_pkg::OFS_CTRL1;
  localparam logic [7:0] A_C2 = frtc_pkg::OFS_CTRL2;
  localparam logic [7:0] A_ST = frtc_pkg::OFS_STATUS;
  localparam logic [7:0] A_SC = frtc_pkg::OFS_STATUS_CLR;
  localparam logic [7:0] A_HI = frtc_pkg::OFS_CNT_HIGH;
  localparam logic [7:0] A_LO = frtc_pkg::OFS_CNT_LOW;
  localparam logic [7:0] A_AH = frtc_pkg::OFS_ALT_HIGH;
  localparam logic [7:0] A_AL = frtc_pkg::OFS_ALT_LOW;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic imask = 1'b0;
  logic halt = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rdata_unb;
  logic irq;
  logic [7:0] d;
  logic [15:0] c;
  logic [7:0] sel [3] = '{8'h04, 8'h00, 8'h08};
  int dv [3] = '{2, 4, 8};
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  frtc_timer u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_EXT_CLOCK_PIN(ext), .I_CPU_IMASK(imask), .I_HALT(halt), .O_IRQ(irq));

  // second copy without the external pin bonded; only its status read back is checked
  frtc_timer #(.EXT_CLOCK_PIN_BONDED(1'b0)) u_dut_unb (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata_unb), .I_EXT_CLOCK_PIN(ext), .I_CPU_IMASK(imask), .I_HALT(halt), .O_IRQ());

  always #10 clk = ~clk;

  // ----------------------------------------
  // run control and reporting
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is about four hundred cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    check({8'h00, d}, {8'h00, e});
  endtask

  // two reads with no gap: the first answer stands while the second strobe is out
  task automatic rd2(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    addr <= b;
    #1 c[15:8] = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 c[7:0] = rdata;
  endtask

  // edges spaced well beyond one core clock
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      ext <= 1'b1;
      repeat (5) @(posedge clk);
      ext <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(A_C1, 8'h00);
    rc(A_C2, 8'h00);
    rc(A_ST, 8'h00);
    check({8'h00, rdata_unb}, 16'h0001);
    rc(A_SC, 8'h00);
    rc(8'h40, 8'h00);
    rc(A_HI, 8'hFF);
    $display("test reset values done");

    wr_reg(A_C2, 8'h0D);
    wr_reg(A_LO, 8'h5A);
    pulse(2);
    rd2(A_HI, A_LO);
    check(c, 16'hFFFE);
    rc(A_HI, 8'hFF);
    pulse(1);
    rc(A_HI, 8'hFF);
    rc(A_LO, 8'hFE);
    rc(A_LO, 8'hFF);
    rd2(A_AH, A_AL);
    check(c, 16'hFFFF);
    wr_reg(A_C2, 8'h0C);
    wr_reg(A_AL, 8'h33);
    @(posedge clk);
    ext <= 1'b1;
    repeat (5) @(posedge clk);
    rc(A_ST, 8'h01);
    rc(A_LO, 8'hFC);
    @(posedge clk);
    ext <= 1'b0;
    repeat (5) @(posedge clk);
    rc(A_LO, 8'hFD);
    $display("test external clock and byte reads done");

    wr_reg(A_C1, 8'h20);
    pulse(3);
    rc(A_LO, 8'h00);
    check({15'h0, irq}, 16'h0001);
    @(posedge clk);
    imask <= 1'b1;
    @(posedge clk);
    #1 check({15'h0, irq}, 16'h0000);
    imask <= 1'b0;
    rc(A_ST, 8'h20);
    rc(A_AL, 8'h00);
    rc(A_ST, 8'h20);
    wr_reg(A_LO, 8'h00);
    rc(A_ST, 8'h00);
    check({15'h0, irq}, 16'h0000);
    $display("test overflow done");

    @(posedge clk);
    halt <= 1'b1;
    pulse(2);
    rc(A_LO, 8'hFC);
    @(posedge clk);
    halt <= 1'b0;
    pulse(4);
    rd2(A_ST, A_LO);
    check(c, 16'h2000);
    rc(A_ST, 8'h00);
    $display("test halt and clear done");

    for (int i = 0; i < 3; i++) begin
      wr_reg(A_C2, sel[i]);
      wr_reg(A_LO, 8'h00);
      repeat (47) @(posedge clk);
      rd2(A_HI, A_LO);
      check(c - 16'hFFFC, 16'(48 / dv[i]));
    end
    rc(A_ST, 8'h20);
    wr_reg(A_SC, 8'h20);
    rc(A_ST, 8'h00);
    $display("test prescaler done");

    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(A_C1, 8'h00);
    rc(A_ST, 8'h00);
    rc(A_HI, 8'hFF);
    $display("test second reset done");
    end_sim();
  end
endmodule // testbench
